// ---- hw/l2_cache_bus.sv ----
// Second-level cache SRAM bus controller: core request side and SRAM pin side.
// Assumes core_clk for the request side and cache_bus_clk, an unrelated clock
// at twice the processor rate, for the SRAM pins; pins outside are two-way.
`default_nettype none

`include "l2_cache_bus_map.svh"

module l2_cache_bus (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic cache_bus_clk,
  input wire logic req_valid,
  input wire l2_cache_bus_pkg::req_t req,
  output var logic req_ready,
  input wire logic abort_req,
  input wire logic write_through,
  output var logic rsp_valid,
  output var logic [`L2_DATA_W-1:0] rsp_data,
  output var logic rsp_last,
  output var logic wr_done,
  output var logic mem_write_fwd,
  output var logic sync_mode,
  input wire logic sram_type_strap,
  input wire logic sync_sram_clock_enable,
  output var logic sram_clock_out,
  output var logic cache_read_enable_a_n,
  output var logic cache_read_enable_b_or_global_write_n,
  output var logic [`L2_LANES-1:0] cache_byte_write_n,
  output var logic [`L2_WAY_W-1:0] cache_way_select,
  output var logic [`L2_ADDR_HI:`L2_ADDR_LO] cache_word_address,
  input wire logic [`L2_DATA_W-1:0] cache_data_bus_in,
  output var logic [`L2_DATA_W-1:0] cache_data_bus_out,
  output var logic cache_data_bus_oe
);

  // ******************************************************************
  // Helper functions
  // ******************************************************************

  // Tag transfers enable two byte lanes per bank
  function automatic logic [`L2_LANES-1:0] lane_mask(input logic tag_access,
                                                     input logic [`L2_LANES-1:0] byte_en);
    logic [`L2_LANES-1:0] m;
    m = byte_en;
    if (tag_access) begin
      for (int b = 0; b < `L2_BANKS; b++) begin
        m[2*b] = byte_en[b];
        m[2*b+1] = byte_en[b];
      end
    end
    return m;
  endfunction : lane_mask

  // Word address of a given word within the 32-byte line
  function automatic logic [`L2_ADDR_W-1:0] line_word(input logic [`L2_ADDR_W-1:0] addr,
                                                      input logic [1:0] beat);
    return {addr[`L2_ADDR_W-1:`L2_LINE_WORD_W], beat};
  endfunction : line_word

  function automatic logic is_read(input l2_cache_bus_pkg::cmd_t cmd);
    return cmd != l2_cache_bus_pkg::CMD_WRITE;
  endfunction : is_read

  // ******************************************************************
  // Core domain
  // ******************************************************************
  logic strap_s2;
  logic ack_s2;
  logic mode_taken_ff;
  l2_cache_bus_pkg::req_t hold_ff;
  logic busy_ff;
  logic nxt_busy;
  logic req_tgl_ff;
  logic ack_seen_ff;
  logic abort_tgl_ff;
  logic abort_pend_ff;
  logic [1:0] beat_ff;
  logic take_req;
  logic ack_event;
  logic next_beat;
  logic beat_good;
  // Link-domain words, stable while the ack toggle is in flight
  logic lnk_abort_ff;
  logic [`L2_DATA_W-1:0] rdata_ff;
  logic ack_tgl_ff;

  cdc_sync2 #(.WIDTH(1)) u_strap_sync (
    .clk(core_clk),
    .din(sram_type_strap),
    .dout(strap_s2)
  );

  cdc_sync2 #(.WIDTH(1)) u_ack_sync (
    .clk(core_clk),
    .din(ack_tgl_ff),
    .dout(ack_s2)
  );

  // Strap taken once on the first edge after reset release
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      mode_taken_ff <= 1'h0;
      sync_mode <= 1'h0;
    end else if (!mode_taken_ff) begin
      mode_taken_ff <= 1'h1;
      sync_mode <= strap_s2;
    end
  end

  // Request acceptance, fill sequencing and completion
  always_comb begin
    take_req = req_valid && req_ready;
    ack_event = busy_ff && (ack_s2 != ack_seen_ff); // Unset sync stages ignored while idle
    beat_good = !lnk_abort_ff && !abort_pend_ff;
    next_beat = hold_ff.cmd == l2_cache_bus_pkg::CMD_FILL && beat_good &&
                beat_ff != `L2_FILL_LAST;
    if (take_req) begin
      nxt_busy = 1'h1;
    end else if (ack_event && !next_beat) begin
      nxt_busy = 1'h0;
    end else begin
      nxt_busy = busy_ff;
    end
  end

  // Hands one single access at a time to the cache bus side
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      hold_ff <= '0;
      busy_ff <= 1'h0;
      req_ready <= 1'h0;
      req_tgl_ff <= 1'h0;
      ack_seen_ff <= 1'h0;
      beat_ff <= `L2_CNT_ZERO;
    end else begin
      busy_ff <= nxt_busy;
      req_ready <= !nxt_busy && mode_taken_ff;
      ack_seen_ff <= ack_s2;
      if (take_req) begin
        hold_ff <= req;
        if (req.cmd == l2_cache_bus_pkg::CMD_FILL) begin
          hold_ff.addr <= line_word(req.addr, `L2_CNT_ZERO);
        end
        req_tgl_ff <= !req_tgl_ff;
        beat_ff <= `L2_CNT_ZERO;
      end else if (ack_event) begin
        if (next_beat) begin
          beat_ff <= beat_ff + `L2_CNT_ONE;
          hold_ff.addr <= line_word(hold_ff.addr, beat_ff + `L2_CNT_ONE);
          req_tgl_ff <= !req_tgl_ff;
        end else begin
          beat_ff <= `L2_CNT_ZERO;
        end
      end
    end
  end

  // Abandon a pending read; writes are never speculative
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      abort_tgl_ff <= 1'h0;
      abort_pend_ff <= 1'h0;
    end else if (ack_event && !next_beat) begin
      abort_pend_ff <= 1'h0;
    end else if (abort_req && busy_ff && !abort_pend_ff && is_read(hold_ff.cmd)) begin
      abort_tgl_ff <= !abort_tgl_ff;
      abort_pend_ff <= 1'h1;
    end
  end

  // Answers to the core and the write policy
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      rsp_valid <= 1'h0;
      rsp_last <= 1'h0;
      rsp_data <= `L2_DATA_RST;
      wr_done <= 1'h0;
      mem_write_fwd <= 1'h0;
    end else begin
      rsp_valid <= ack_event && is_read(hold_ff.cmd) && beat_good;
      rsp_last <= ack_event && is_read(hold_ff.cmd) && beat_good && !next_beat;
      if (ack_event) begin
        rsp_data <= rdata_ff;
      end
      wr_done <= ack_event && hold_ff.cmd == l2_cache_bus_pkg::CMD_WRITE;
      mem_write_fwd <= ack_event && hold_ff.cmd == l2_cache_bus_pkg::CMD_WRITE &&
                       write_through;
    end
  end

  // ******************************************************************
  // Cache bus domain
  // ******************************************************************
  logic lrst_b;
  logic req_s2;
  logic abort_s2;
  logic mode_s2;
  logic sync_sram_clock_enable_s2;
  logic req_seen_ff;
  logic abort_seen_ff;
  logic new_req;
  logic abort_edge;
  logic [`L2_DATA_W-1:0] din_s1_ff;
  logic [`L2_DATA_W-1:0] din_s2_ff;
  logic [1:0] cnt_ff;
  logic [`L2_LANES-1:0] lanes_ff;
  l2_cache_bus_pkg::link_state_t state_ff;

  cdc_sync2 #(.WIDTH(5)) u_link_sync (
    .clk(cache_bus_clk),
    .din({rst_b, req_tgl_ff, abort_tgl_ff, sync_mode, sync_sram_clock_enable}),
    .dout({lrst_b, req_s2, abort_s2, mode_s2, sync_sram_clock_enable_s2})
  );

  assign new_req = req_s2 != req_seen_ff;
  assign abort_edge = abort_s2 != abort_seen_ff;

  // Read data passes two stages before use
  always_ff @(posedge cache_bus_clk) begin
    din_s1_ff <= cache_data_bus_in;
    din_s2_ff <= din_s1_ff;
  end

  // SRAM clock toggles on every link edge, giving the core rate
  always_ff @(posedge cache_bus_clk) begin
    if (!lrst_b) begin
      sram_clock_out <= 1'h0;
    end else if (mode_s2 && sync_sram_clock_enable_s2) begin
      sram_clock_out <= !sram_clock_out;
    end else begin
      sram_clock_out <= 1'h0;
    end
  end

  // Access sequencer: one address phase per access, never a burst
  always_ff @(posedge cache_bus_clk) begin
    if (!lrst_b) begin
      state_ff <= l2_cache_bus_pkg::L_IDLE;
      cnt_ff <= `L2_CNT_ZERO;
      req_seen_ff <= 1'h0;
      abort_seen_ff <= 1'h0;
      ack_tgl_ff <= 1'h0;
      lnk_abort_ff <= 1'h0;
      rdata_ff <= `L2_DATA_RST;
      lanes_ff <= '0;
      cache_read_enable_a_n <= `L2_PIN_OFF_N;
      cache_read_enable_b_or_global_write_n <= `L2_PIN_OFF_N;
      cache_byte_write_n <= `L2_LANES_OFF_N;
      cache_way_select <= `L2_WAY_RST;
      cache_word_address <= `L2_ADDR_RST;
      cache_data_bus_out <= `L2_DATA_RST;
      cache_data_bus_oe <= 1'h0;
    end else begin
      abort_seen_ff <= abort_s2;
      case (state_ff)
        l2_cache_bus_pkg::L_IDLE: begin
          if (new_req) begin
            req_seen_ff <= req_s2;
            lnk_abort_ff <= 1'h0;
            cnt_ff <= `L2_CNT_ZERO;
            cache_way_select <= hold_ff.way;
            cache_word_address <= hold_ff.addr;
            lanes_ff <= lane_mask(hold_ff.tag_access, hold_ff.byte_en);
            if (is_read(hold_ff.cmd)) begin
              state_ff <= l2_cache_bus_pkg::L_READ;
              cache_read_enable_a_n <= `L2_PIN_ON_N;
              cache_read_enable_b_or_global_write_n <= mode_s2 ? `L2_PIN_OFF_N :
                                                       `L2_PIN_ON_N;
            end else begin
              state_ff <= l2_cache_bus_pkg::L_WRITE;
              cache_data_bus_out <= hold_ff.wdata;
              cache_data_bus_oe <= 1'h1;
              cache_byte_write_n <= ~lane_mask(hold_ff.tag_access, hold_ff.byte_en);
              cache_read_enable_b_or_global_write_n <= mode_s2 ? `L2_PIN_ON_N :
                                                       `L2_PIN_OFF_N;
            end
          end
        end
        l2_cache_bus_pkg::L_READ: begin
          cnt_ff <= cnt_ff + `L2_CNT_ONE;
          if (abort_edge) begin
            lnk_abort_ff <= 1'h1;
            state_ff <= l2_cache_bus_pkg::L_DONE;
          end else if (cnt_ff == `L2_READ_LAST) begin
            rdata_ff <= din_s2_ff;
            state_ff <= l2_cache_bus_pkg::L_DONE;
          end
        end
        l2_cache_bus_pkg::L_WRITE: begin
          cnt_ff <= cnt_ff + `L2_CNT_ONE;
          if (cnt_ff == `L2_WRITE_LAST) begin
            state_ff <= l2_cache_bus_pkg::L_DONE;
          end
        end
        l2_cache_bus_pkg::L_DONE: begin
          // Release the pins and hand the result back
          cache_read_enable_a_n <= `L2_PIN_OFF_N;
          cache_read_enable_b_or_global_write_n <= `L2_PIN_OFF_N;
          cache_byte_write_n <= `L2_LANES_OFF_N;
          cache_data_bus_oe <= 1'h0;
          ack_tgl_ff <= !ack_tgl_ff;
          state_ff <= l2_cache_bus_pkg::L_IDLE;
        end
        default: begin
          state_ff <= l2_cache_bus_pkg::L_IDLE;
        end
      endcase
    end
  end

  // ******************************************************************
  // Checks
  // ******************************************************************
  sequence s_read_start;
    state_ff == l2_cache_bus_pkg::L_IDLE && new_req && is_read(hold_ff.cmd);
  endsequence

  sequence s_clean_read;
    (state_ff == l2_cache_bus_pkg::L_READ && !abort_edge)[*3];
  endsequence

  a_read_third_phase: assert property (@(posedge cache_bus_clk) disable iff (!lrst_b)
    s_read_start ##1 s_clean_read |=> state_ff == l2_cache_bus_pkg::L_DONE)
    else $error("read data not taken on third phase");

  a_access_spacing: assert property (@(posedge cache_bus_clk) disable iff (!lrst_b)
    (state_ff == l2_cache_bus_pkg::L_IDLE && new_req) |=>
      (state_ff != l2_cache_bus_pkg::L_IDLE)[*2])
    else $error("access shorter than two clocks");

  a_abort_ends_read: assert property (@(posedge cache_bus_clk) disable iff (!lrst_b)
    (state_ff == l2_cache_bus_pkg::L_READ && abort_edge) |=>
      state_ff == l2_cache_bus_pkg::L_DONE && lnk_abort_ff ##1 cache_read_enable_a_n)
    else $error("abandoned read not ended");

  a_lane_strobes: assert property (@(posedge cache_bus_clk) disable iff (!lrst_b)
    state_ff == l2_cache_bus_pkg::L_WRITE |-> cache_byte_write_n == ~lanes_ff &&
      cache_data_bus_oe)
    else $error("byte strobes do not match lanes");

  a_global_write: assert property (@(posedge cache_bus_clk) disable iff (!lrst_b)
    state_ff == l2_cache_bus_pkg::L_WRITE |->
      cache_read_enable_b_or_global_write_n == !mode_s2)
    else $error("second enable wrong during write");

  a_way_stable: assert property (@(posedge cache_bus_clk) disable iff (!lrst_b)
    (state_ff == l2_cache_bus_pkg::L_READ || state_ff == l2_cache_bus_pkg::L_WRITE) |=>
      $stable(cache_way_select) && $stable(cache_word_address))
    else $error("way or address moved mid access");

  a_sram_clock_rate: assert property (@(posedge cache_bus_clk) disable iff (!lrst_b)
    (mode_s2 && sync_sram_clock_enable_s2)[*2] |=> sram_clock_out != $past(sram_clock_out))
    else $error("sram clock not toggling each edge");

  a_sram_clock_off: assert property (@(posedge cache_bus_clk) disable iff (!lrst_b)
    !mode_s2 |=> !sram_clock_out)
    else $error("sram clock running in asynchronous mode");

  a_fill_last: assert property (@(posedge core_clk) disable iff (!rst_b)
    (rsp_valid && !rsp_last) |-> hold_ff.cmd == l2_cache_bus_pkg::CMD_FILL &&
      beat_ff != `L2_CNT_ZERO && busy_ff)
    else $error("fill word count out of step");

  a_policy_forward: assert property (@(posedge core_clk) disable iff (!rst_b)
    mem_write_fwd |-> wr_done && $past(write_through))
    else $error("write forwarded without write-through");

endmodule : l2_cache_bus

`default_nettype wire

// ---- hw/l2_cache_bus_map.svh ----
// Constants for the second-level cache SRAM bus controller.
// Assumes inclusion by the package and the controller; holds defines only.
`ifndef L2_CACHE_BUS_MAP_SVH
`define L2_CACHE_BUS_MAP_SVH

// ********************************************************************
// Bus geometry
// ********************************************************************
`define L2_DATA_W 64
`define L2_LANES 8
`define L2_BANKS 4
`define L2_WAY_W 2
`define L2_ADDR_HI 17
`define L2_ADDR_LO 3
`define L2_ADDR_W 15
`define L2_LINE_WORD_W 2

// ********************************************************************
// Sequencing counts
// ********************************************************************
`define L2_FILL_LAST 2'h3
`define L2_READ_LAST 2'h2
`define L2_WRITE_LAST 2'h1
`define L2_CNT_ZERO 2'h0
`define L2_CNT_ONE 2'h1

// ********************************************************************
// Pin and reset values
// ********************************************************************
`define L2_PIN_OFF_N 1'h1
`define L2_PIN_ON_N 1'h0
`define L2_LANES_OFF_N 8'hFF
`define L2_ADDR_RST 15'h0000
`define L2_WAY_RST 2'h0
`define L2_DATA_RST 64'h0000_0000_0000_0000

`endif

// ---- hw/l2_cache_bus_pkg.sv ----
// Types shared by the second-level cache SRAM bus controller.
// Assumes the constants header is on the include path.
`default_nettype none

`include "l2_cache_bus_map.svh"

package l2_cache_bus_pkg;

  // ******************************************************************
  // Commands and states
  // ******************************************************************
  typedef enum logic [1:0] {
    CMD_READ = 2'h0,
    CMD_WRITE = 2'h1,
    CMD_FILL = 2'h2
  } cmd_t;

  typedef enum logic [1:0] {
    L_IDLE = 2'h0,
    L_READ = 2'h1,
    L_WRITE = 2'h2,
    L_DONE = 2'h3
  } link_state_t;

  // ******************************************************************
  // Request carried from the core to the cache bus
  // ******************************************************************
  typedef struct packed {
    cmd_t cmd;
    logic tag_access;
    logic [`L2_WAY_W-1:0] way;
    logic [`L2_ADDR_W-1:0] addr;
    logic [`L2_DATA_W-1:0] wdata;
    logic [`L2_LANES-1:0] byte_en;
  } req_t;

endpackage : l2_cache_bus_pkg

`default_nettype wire

// ---- hw/cdc_sync2.sv ----
// Two-stage synchroniser for levels and toggles entering a clock domain.
// Assumes the input changes no faster than the destination clock can see.
`default_nettype none

module cdc_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic [WIDTH-1:0] din,
  output var logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_ff;

  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    meta_ff <= din;
    dout <= meta_ff;
  end

endmodule : cdc_sync2

`default_nettype wire

// ---- bench/sram_array_model.sv ----
// External SRAM cache array seen from the cache bus pins.
// Assumes the bench resolves the shared data wire and feeds it back here.
`default_nettype none

module sram_array_model (
  input wire logic cache_bus_clk,
  input wire logic sync_mode,
  input wire logic read_a_n,
  input wire logic read_b_n,
  input wire logic [7:0] byte_write_n,
  input wire logic [1:0] way,
  input wire logic [17:3] word_addr,
  input wire logic [63:0] wr_data,
  output var logic [63:0] rd_data
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Storage and read path
  // ****************************************************************
  logic [63:0] mem [logic [16:0]];
  logic [63:0] junk_q = 64'h0;
  logic rd_on;

  // Async needs both read enables, sync uses the first one only
  assign rd_on = !read_a_n && (sync_mode || !read_b_n);

  // Released wire shows a pattern that flips every link cycle
  always @(posedge cache_bus_clk) junk_q <= ~junk_q;

  // Way and word address pick the stored word
  always @* rd_data = rd_on ? mem[{way, word_addr}] : junk_q;

  // ****************************************************************
  // Write path
  // ****************************************************************
  // Each low strobe writes its own lane; sync mode also needs global write
  always @(posedge cache_bus_clk) begin
    for (int i = 0; i < 8; i++) begin
      if (!byte_write_n[i] && (!sync_mode || !read_b_n)) begin
        mem[{way, word_addr}][8*i +: 8] <= wr_data[8*i +: 8];
      end
    end
  end
endmodule : sram_array_model

`default_nettype wire

// ---- bench/l2_sram_cache_bus_bench.sv ----
// Self-checking bench for the cache SRAM bus controller.
// Assumes the SRAM model sits on the pins and the package is compiled first.
`default_nettype none

`define CHK(nm, exp, got) begin tests_run++; if ((exp) !== (got)) begin n_fail++; \
  $display("wrong value %s expected %h seen %h", nm, exp, got); end end

module l2_sram_cache_bus_bench;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Signals, clocks and the blocks under test
  // ****************************************************************
  logic core_clk = 1'b0, cache_bus_clk = 1'b0, rst_b, req_valid, req_ready, abort_req;
  logic write_through, rsp_valid, rsp_last, wr_done, mem_write_fwd, sync_mode;
  logic sram_type_strap, sync_sram_clock_enable, sram_clock_out, cache_read_enable_a_n;
  logic cache_read_enable_b_or_global_write_n, cache_data_bus_oe;
  logic [7:0] cache_byte_write_n;
  logic [1:0] cache_way_select;
  logic [17:3] cache_word_address;
  logic [63:0] rsp_data, cache_data_bus_in, cache_data_bus_out, sram_q;
  l2_cache_bus_pkg::req_t req;
  logic [63:0] ref_mem [logic [16:0]];
  logic [63:0] got_q [$];
  logic got_l [$];
  logic prev_v = 1'b0, sck_q = 1'b0;
  int n_fail = 0, tests_run = 0, n_rsp = 0, n_wr = 0, n_fwd = 0, n_last = 0, toggles = 0;
  int seed;

  always #25 core_clk = ~core_clk;
  always #15 cache_bus_clk = ~cache_bus_clk;

  // Whoever drives decides the wire level
  assign cache_data_bus_in = cache_data_bus_oe ? cache_data_bus_out : sram_q;

  l2_cache_bus DUT (.core_clk, .rst_b, .cache_bus_clk, .req_valid, .req, .req_ready,
    .abort_req, .write_through, .rsp_valid, .rsp_data, .rsp_last, .wr_done, .mem_write_fwd,
    .sync_mode, .sram_type_strap, .sync_sram_clock_enable, .sram_clock_out,
    .cache_read_enable_a_n, .cache_read_enable_b_or_global_write_n, .cache_byte_write_n,
    .cache_way_select, .cache_word_address, .cache_data_bus_in, .cache_data_bus_out,
    .cache_data_bus_oe);

  sram_array_model mem_model (.cache_bus_clk, .sync_mode, .read_a_n(cache_read_enable_a_n),
    .read_b_n(cache_read_enable_b_or_global_write_n), .byte_write_n(cache_byte_write_n),
    .way(cache_way_select), .word_addr(cache_word_address), .wr_data(cache_data_bus_in),
    .rd_data(sram_q));

  // ****************************************************************
  // Monitors
  // ****************************************************************
  // Collect answers; two words never come on adjacent core cycles
  always @(posedge core_clk) begin
    if (rst_b === 1'b1 && rsp_valid === 1'b1) begin
      `CHK("word spacing", 1'b0, prev_v)
      got_q.push_back(rsp_data);
      got_l.push_back(rsp_last);
      n_rsp++;
      n_last += (rsp_last === 1'b1);
    end
    if (rst_b === 1'b1 && wr_done === 1'b1) begin
      n_wr++;
      n_fwd += (mem_write_fwd === 1'b1);
    end
    prev_v = rsp_valid;
  end

  // Count edges of the SRAM clock pin
  always @(posedge cache_bus_clk) begin
    if (rst_b === 1'b1 && sram_clock_out !== sck_q) toggles++;
    sck_q <= sram_clock_out;
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize

  task automatic do_reset(input logic strap);
    rst_b <= 1'b0;
    sram_type_strap <= strap;
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge core_clk);
  endtask : do_reset

  task automatic settle(input int r, input int wv);
    int t;
    t = 0;
    while ((n_rsp < r || n_wr < wv) && t < 80) begin
      @(posedge core_clk);
      t++;
    end
    `CHK("completion", 1'b1, t < 80)
  endtask : settle

  // Offer a request and hold it until the edge that takes it
  task automatic xfer(input l2_cache_bus_pkg::cmd_t c, input logic tg, input logic [1:0] w,
    input logic [14:0] a, input logic [63:0] d, input logic [7:0] be);
    int t;
    t = 0;
    req_valid <= 1'b1;
    req <= '{cmd: c, tag_access: tg, way: w, addr: a, wdata: d, byte_en: be};
    do begin
      @(posedge core_clk);
      t++;
    end while (req_ready !== 1'b1 && t < 100);
    req_valid <= 1'b0;
    `CHK("request taken", 1'b1, t < 100)
  endtask : xfer

  // One access against the reference memory
  task automatic op(input l2_cache_bus_pkg::cmd_t c, input logic tg, input logic [1:0] w,
    input logic [14:0] a, input logic [7:0] be);
    logic [63:0] d, gd;
    logic [14:0] s;
    logic gl;
    int n, r0, w0;
    d = {$random(seed), $random(seed)};
    n = (c == l2_cache_bus_pkg::CMD_FILL) ? 4 : 1;
    s = (n == 4) ? (a & 15'h7FFC) : a;
    r0 = n_rsp;
    w0 = n_wr;
    xfer(c, tg, w, a, d, be);
    if (c == l2_cache_bus_pkg::CMD_WRITE) begin
      for (int i = 0; i < 8; i++) begin
        if (tg ? be[i/2] : be[i]) ref_mem[{w, a}][8*i +: 8] = d[8*i +: 8];
      end
      settle(r0, w0 + 1);
    end else begin
      settle(r0 + n, w0);
      for (int i = 0; i < n; i++) begin
        gd = got_q.pop_front();
        gl = got_l.pop_front();
        `CHK("read word", ref_mem[{w, s + 15'(i)}], gd)
        `CHK("last flag", (i == n - 1), gl)
      end
    end
  endtask : op

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    int f0, r0, l0, t0;
    logic [1:0] w;
    logic [14:0] base;
    seed = 32'h223d;
    rst_b = 1'b0;
    req_valid = 1'b0;
    req = '0;
    abort_req = 1'b0;
    write_through = 1'b0;
    sram_type_strap = 1'b0;
    sync_sram_clock_enable = 1'b1;
    do_reset(1'b0);
    `CHK("async mode", 1'b0, sync_mode)
    w = 2'($random(seed));
    base = 15'($random(seed)) & 15'h7FFC;
    for (int k = 0; k < 4; k++) begin
      f0 = n_fwd;
      write_through <= k[0];
      op(l2_cache_bus_pkg::CMD_WRITE, 1'b0, w, base + 15'(k), 8'hFF);
      `CHK("forward count", f0 + k % 2, n_fwd)
    end
    op(l2_cache_bus_pkg::CMD_WRITE, 1'b0, w, base + 15'h1, 8'($random(seed)) | 8'h01);
    op(l2_cache_bus_pkg::CMD_WRITE, 1'b1, w, base + 15'h2,
       (8'($random(seed)) & 8'h0F) | 8'h01);
    op(l2_cache_bus_pkg::CMD_READ, 1'b0, w, base + 15'h1, 8'hFF);
    op(l2_cache_bus_pkg::CMD_READ, 1'b1, w, base + 15'h2, 8'h0F);
    op(l2_cache_bus_pkg::CMD_FILL, 1'b0, w, base + 15'h2, 8'hFF);
    for (int k = 0; k < 4; k++) op(l2_cache_bus_pkg::CMD_WRITE, 1'b0, 2'(k), 15'h7FFF, 8'hFF);
    for (int k = 0; k < 4; k++) op(l2_cache_bus_pkg::CMD_READ, 1'b0, 2'(k), 15'h7FFF, 8'hFF);
    `CHK("no clock in async", 0, toggles)
    r0 = n_rsp;
    l0 = n_last;
    xfer(l2_cache_bus_pkg::CMD_FILL, 1'b0, w, base, 64'h0, 8'hFF);
    settle(r0 + 1, n_wr);
    abort_req <= 1'b1;
    @(posedge core_clk);
    abort_req <= 1'b0;
    repeat (40) @(posedge core_clk);
    `CHK("fill cut short", 1'b1, n_rsp - r0 < 4)
    `CHK("no last after abort", l0, n_last)
    got_q.delete();
    got_l.delete();
    op(l2_cache_bus_pkg::CMD_READ, 1'b0, w, base + 15'h3, 8'hFF);
    do_reset(1'b1);
    `CHK("sync mode", 1'b1, sync_mode)
    t0 = toggles;
    repeat (10) @(posedge core_clk);
    `CHK("sram clock rate", 1'b1, toggles - t0 >= 15)
    op(l2_cache_bus_pkg::CMD_WRITE, 1'b0, w, base, 8'($random(seed)) | 8'h01);
    op(l2_cache_bus_pkg::CMD_READ, 1'b0, w, base, 8'hFF);
    sync_sram_clock_enable <= 1'b0;
    repeat (10) @(posedge core_clk);
    t0 = toggles;
    repeat (10) @(posedge core_clk);
    `CHK("sram clock stopped", t0, toggles)
    `CHK("sram clock low", 1'b0, sram_clock_out)
    summarize();
  end

  // Cut a hang short well past the expected run length
  initial begin
    #2000000;
    n_fail++;
    summarize();
  end
endmodule : l2_sram_cache_bus_bench

`undef CHK
`default_nettype wire
